// *** common/trr_pkg.sv ***
// constants, field layout and encodings for the role resolution block
// assumes a single 100 MHz core clock
package trr_pkg;
  // clock and page-exchange timeout
  localparam int CLK_PERIOD_NS = 10;
  localparam int PAGE_TIMEOUT_NS = 10000;
  localparam int PAGE_TIMEOUT_CYC = (PAGE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMO_W = 10;
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(PAGE_TIMEOUT_CYC - 1);
  localparam logic [TMO_W-1:0] TMO_ONE = 10'h001;
  localparam logic [TMO_W-1:0] TMO_ZERO = 10'h000;

  // advertisement words
  localparam int ADV_W = 16;
  localparam int PREF_BIT = 4;
  localparam int FORCE_BIT = 6;
  localparam logic [ADV_W-1:0] ADV_HIGH_RST = 16'h0000;
  localparam logic [ADV_W-1:0] ADV_LOW_RST = 16'h0000;

  // random tie-break seed
  localparam int SEED_W = 4;
  localparam int LFSR_W = 8;
  localparam logic [LFSR_W-1:0] LFSR_INIT = 8'hA5;
  localparam logic [LFSR_W-1:0] LFSR_TAPS = 8'hB8;

  // role result encoding
  typedef logic [1:0] trr_role_t;
  localparam trr_role_t ROLE_SLAVE = 2'h0;
  localparam trr_role_t ROLE_MASTER = 2'h1;
  localparam trr_role_t ROLE_FAULT = 2'h2;

  typedef enum logic [1:0] {ST_START, ST_EXCHANGE, ST_RESOLVE, ST_DONE} trr_state_e;

  function automatic trr_role_t trr_role_of(input logic master);
    trr_role_of = master ? ROLE_MASTER : ROLE_SLAVE;
  endfunction
endpackage

// *** common/trr_res_if.sv ***
// bundle between the negotiation engine and the role resolver
// purely combinational path, one clock domain
`timescale 1ns/1ns
`default_nettype none
interface trr_res_if;
  import trr_pkg::*;
  logic loc_force;
  logic loc_pref;
  logic par_force;
  logic par_pref;
  logic [SEED_W-1:0] loc_seed;
  logic [SEED_W-1:0] par_seed;
  trr_role_t role;
  logic fault;
  logic tie;
  modport user (output loc_force, loc_pref, par_force, par_pref, loc_seed, par_seed,
    input role, fault, tie);
  modport resolver (input loc_force, loc_pref, par_force, par_pref, loc_seed, par_seed,
    output role, fault, tie);
endinterface
`default_nettype wire

// *** verilog/trr_lfsr.sv ***
// free-running pseudo-random source for the tie-break seed
// assumes sys_clk and async active-low resetn
`timescale 1ns/1ns
`default_nettype none
module trr_lfsr (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // random value
  output logic [trr_pkg::LFSR_W-1:0] rnd_value
);
  import trr_pkg::*;
  logic [LFSR_W-1:0] lfsr_reg;
  logic [LFSR_W-1:0] lfsr_next;

  always_comb
  begin
    lfsr_next = {1'b0, lfsr_reg[LFSR_W-1:1]};
    if (lfsr_reg[0])
    begin
      lfsr_next = lfsr_next ^ LFSR_TAPS;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lfsr_reg <= LFSR_INIT;
    end
    else
    begin
      lfsr_reg <= lfsr_next;
    end
  end

  assign rnd_value = lfsr_reg;
endmodule
`default_nettype wire

// *** verilog/trr_resolver.sv ***
// master/slave resolution from local and partner advertisements
// combinational; inputs held stable by the engine
`timescale 1ns/1ns
`default_nettype none
module trr_resolver (
  // resolver side of the bundle
  trr_res_if.resolver rs
);
  import trr_pkg::*;

  always_comb
  begin
    rs.fault = 1'b0;
    rs.tie = 1'b0;
    rs.role = ROLE_SLAVE;
    if (rs.loc_force && rs.par_force)
    begin
      if (rs.loc_pref == rs.par_pref)
      begin
        rs.fault = 1'b1;
        rs.role = ROLE_FAULT;
      end
      else
      begin
        rs.role = trr_role_of(rs.loc_pref);
      end
    end
    else if (rs.loc_force)
    begin
      rs.role = trr_role_of(rs.loc_pref);
    end
    else if (rs.par_force)
    begin
      rs.role = trr_role_of(!rs.par_pref);
    end
    else if (rs.loc_pref != rs.par_pref)
    begin
      rs.role = trr_role_of(rs.loc_pref);
    end
    else
    begin
      // mirrored compare at the partner yields the opposite role
      rs.tie = (rs.loc_seed == rs.par_seed);
      rs.role = trr_role_of(rs.loc_seed > rs.par_seed);
    end
  end
endmodule
`default_nettype wire

// *** verilog/trr_role_resolution.sv ***
// role negotiation engine for one single-pair port
// assumes page exchange signals are synchronous to sys_clk
`timescale 1ns/1ns
`default_nettype none
module trr_role_resolution #(
  parameter logic PORT_PREFERS_MASTER = 1'b1
) (
  // clock and resets
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic sw_reset,
  // advertisement register access
  input wire logic adv_high_wr_en,
  input wire logic [trr_pkg::ADV_W-1:0] adv_high_wdata,
  input wire logic adv_low_wr_en,
  input wire logic [trr_pkg::ADV_W-1:0] adv_low_wdata,
  output logic [trr_pkg::ADV_W-1:0] an_advert_ability_high,
  output logic [trr_pkg::ADV_W-1:0] an_advert_ability_low,
  // control
  input wire logic an_restart,
  // page exchange with the link partner
  output logic page_tx_valid,
  output logic page_tx_force,
  output logic page_tx_pref,
  output logic [trr_pkg::SEED_W-1:0] page_tx_seed,
  input wire logic page_rx_valid,
  input wire logic page_rx_force,
  input wire logic page_rx_pref,
  input wire logic [trr_pkg::SEED_W-1:0] page_rx_seed,
  input wire logic link_quality_ok,
  // status
  output logic negotiation_complete,
  output trr_pkg::trr_role_t role_result,
  output logic partner_role_force,
  output logic partner_role_pref,
  output logic link_status
);
  import trr_pkg::*;

  localparam logic [ADV_W-1:0] PREF_MASK = ADV_W'(1) << PREF_BIT;
  localparam logic [ADV_W-1:0] HIGH_DEFAULT =
    PORT_PREFERS_MASTER ? (ADV_HIGH_RST | PREF_MASK) : (ADV_HIGH_RST & ~PREF_MASK);

  trr_res_if rs ();
  logic [LFSR_W-1:0] rnd_value;

  trr_lfsr u_lfsr (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .rnd_value(rnd_value)
  );

  trr_resolver u_resolver (
    .rs(rs)
  );

  // advertisement registers
  logic [ADV_W-1:0] adv_high_reg;
  logic [ADV_W-1:0] adv_high_next;
  logic [ADV_W-1:0] adv_low_reg;
  logic [ADV_W-1:0] adv_low_next;

  always_comb
  begin
    adv_high_next = adv_high_reg;
    adv_low_next = adv_low_reg;
    if (sw_reset)
    begin
      adv_high_next = HIGH_DEFAULT;
      adv_low_next = ADV_LOW_RST;
    end
    else
    begin
      if (adv_high_wr_en)
      begin
        adv_high_next = adv_high_wdata;
      end
      if (adv_low_wr_en)
      begin
        adv_low_next = adv_low_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      adv_high_reg <= HIGH_DEFAULT;
      adv_low_reg <= ADV_LOW_RST;
    end
    else
    begin
      adv_high_reg <= adv_high_next;
      adv_low_reg <= adv_low_next;
    end
  end

  assign an_advert_ability_high = adv_high_reg;
  assign an_advert_ability_low = adv_low_reg;

  // negotiation engine state
  trr_state_e state_reg;
  trr_state_e state_next;
  logic [TMO_W-1:0] tmo_reg;
  logic [TMO_W-1:0] tmo_next;
  logic [SEED_W-1:0] seed_reg;
  logic [SEED_W-1:0] seed_next;
  logic par_force_reg;
  logic par_force_next;
  logic par_pref_reg;
  logic par_pref_next;
  logic [SEED_W-1:0] par_seed_reg;
  logic [SEED_W-1:0] par_seed_next;
  trr_role_t role_reg;
  trr_role_t role_next;
  logic complete_reg;
  logic complete_next;
  logic link_reg;
  logic link_next;
  logic tx_valid_reg;
  logic tx_valid_next;

  assign rs.loc_force = adv_low_reg[FORCE_BIT];
  assign rs.loc_pref = adv_high_reg[PREF_BIT];
  assign rs.par_force = par_force_reg;
  assign rs.par_pref = par_pref_reg;
  assign rs.loc_seed = seed_reg;
  assign rs.par_seed = par_seed_reg;

  always_comb
  begin
    state_next = state_reg;
    tmo_next = TMO_ZERO;
    seed_next = seed_reg;
    par_force_next = par_force_reg;
    par_pref_next = par_pref_reg;
    par_seed_next = par_seed_reg;
    role_next = role_reg;
    complete_next = complete_reg;
    unique case (state_reg)
      ST_START:
      begin
        seed_next = rnd_value[SEED_W-1:0];
        state_next = ST_EXCHANGE;
      end
      ST_EXCHANGE:
      begin
        tmo_next = tmo_reg + TMO_ONE;
        if (page_rx_valid)
        begin
          par_force_next = page_rx_force;
          par_pref_next = page_rx_pref;
          par_seed_next = page_rx_seed;
          state_next = ST_RESOLVE;
        end
        else if (tmo_reg == TMO_LAST)
        begin
          state_next = ST_START;
        end
      end
      ST_RESOLVE:
      begin
        role_next = rs.role;
        if (rs.fault || rs.tie || !link_quality_ok)
        begin
          state_next = ST_START;
        end
        else
        begin
          complete_next = 1'b1;
          state_next = ST_DONE;
        end
      end
      ST_DONE:
      begin
        if (!link_quality_ok)
        begin
          state_next = ST_START;
        end
      end
    endcase
    if (an_restart && state_reg != ST_START)
    begin
      state_next = ST_START;
    end
    if (state_next == ST_START)
    begin
      complete_next = 1'b0;
    end
    if (sw_reset)
    begin
      state_next = ST_START;
      tmo_next = TMO_ZERO;
      par_force_next = 1'b0;
      par_pref_next = 1'b0;
      par_seed_next = '0;
      role_next = ROLE_SLAVE;
      complete_next = 1'b0;
    end
    link_next = complete_next && link_quality_ok;
    tx_valid_next = (state_next == ST_EXCHANGE);
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= ST_START;
      tmo_reg <= TMO_ZERO;
      seed_reg <= '0;
      par_force_reg <= 1'b0;
      par_pref_reg <= 1'b0;
      par_seed_reg <= '0;
      role_reg <= ROLE_SLAVE;
      complete_reg <= 1'b0;
      link_reg <= 1'b0;
      tx_valid_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      tmo_reg <= tmo_next;
      seed_reg <= seed_next;
      par_force_reg <= par_force_next;
      par_pref_reg <= par_pref_next;
      par_seed_reg <= par_seed_next;
      role_reg <= role_next;
      complete_reg <= complete_next;
      link_reg <= link_next;
      tx_valid_reg <= tx_valid_next;
    end
  end

  // page force and preference bits follow the advertisement registers; the page seed is seed_reg
  logic tx_force_reg;
  logic tx_pref_reg;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_force_reg <= 1'b0;
      tx_pref_reg <= 1'b0;
    end
    else
    begin
      tx_force_reg <= adv_low_next[FORCE_BIT];
      tx_pref_reg <= adv_high_next[PREF_BIT];
    end
  end

  assign page_tx_valid = tx_valid_reg;
  assign page_tx_force = tx_force_reg;
  assign page_tx_pref = tx_pref_reg;
  assign page_tx_seed = seed_reg;
  assign negotiation_complete = complete_reg;
  assign role_result = role_reg;
  assign partner_role_force = par_force_reg;
  assign partner_role_pref = par_pref_reg;
  assign link_status = link_reg;

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_fail;
    state_reg == ST_RESOLVE && rs.fault && !sw_reset;
  endsequence

  sequence s_restart_seen;
    !page_tx_valid ##1 page_tx_valid;
  endsequence

  AST_PREF_WRITE:
    assert property (adv_high_wr_en && !sw_reset |=> an_advert_ability_high == $past(adv_high_wdata))
    else $error("preference word not written");
  AST_PREF_DEFAULT:
    assert property (sw_reset |=> an_advert_ability_high[PREF_BIT] == PORT_PREFERS_MASTER)
    else $error("preference default not restored");
  AST_FORCE_PAGE:
    assert property (adv_low_wr_en && !sw_reset |=> page_tx_force == $past(adv_low_wdata[FORCE_BIT]))
    else $error("force bit not advertised");
  AST_CAPTURE:
    assert property (state_reg == ST_EXCHANGE && page_rx_valid && !sw_reset
      |=> partner_role_pref == $past(page_rx_pref) && partner_role_force == $past(page_rx_force))
    else $error("partner bits not captured");
  AST_RESULT_VALID:
    assert property ($rose(negotiation_complete) |-> role_result != ROLE_FAULT && $past(state_reg == ST_RESOLVE))
    else $error("complete without a valid role");
  AST_RANDOM:
    assert property (!rs.loc_force && !rs.par_force && rs.loc_pref == rs.par_pref && rs.tie
      && state_reg == ST_RESOLVE && !sw_reset && !an_restart |=> state_reg == ST_START)
    else $error("seed tie did not retry");
  AST_PREF_DIFF:
    assert property (!rs.loc_force && !rs.par_force && rs.loc_pref != rs.par_pref
      |-> rs.role == (rs.loc_pref ? ROLE_MASTER : ROLE_SLAVE))
    else $error("differing preferences misresolved");
  AST_ONE_FORCE:
    assert property (rs.loc_force != rs.par_force
      |-> rs.role == (rs.loc_force ? trr_role_of(rs.loc_pref) : trr_role_of(!rs.par_pref)))
    else $error("single force misresolved");
  AST_BOTH_FORCE:
    assert property (rs.loc_force && rs.par_force |-> rs.fault == (rs.loc_pref == rs.par_pref))
    else $error("double force misresolved");
  AST_ONE_MASTER:
    assert property (!rs.fault && !rs.tie && rs.par_force == rs.loc_force && !rs.loc_force
      && rs.loc_pref == rs.par_pref |-> (rs.role == ROLE_MASTER) == (rs.loc_seed > rs.par_seed))
    else $error("tie-break not antisymmetric");
  AST_FAIL_RESTART:
    assert property (s_fail ##1 !sw_reset |-> s_restart_seen)
    else $error("fault did not restart negotiation");
  AST_TIMEOUT:
    assert property (state_reg == ST_EXCHANGE && tmo_reg == TMO_LAST && !page_rx_valid && !sw_reset
      |=> state_reg == ST_START && !negotiation_complete)
    else $error("page timeout did not restart");
  AST_LINK_DOWN:
    assert property (!negotiation_complete |-> !link_status)
    else $error("link up before completion");
  AST_HOLD:
    assert property (state_reg == ST_DONE && !sw_reset |=> $stable(role_result) && $stable(partner_role_pref))
    else $error("result changed outside an attempt");
  AST_COMPLETE_CLEAR:
    assert property (state_reg == ST_START |-> !negotiation_complete)
    else $error("complete held across restart");
endmodule
`default_nettype wire

// *** tb/trr_partner_model.sv ***
// remote link partner: answers each local exchange window with one page
// assumes pages are synchronous to sys_clk and the bench sets cfg_* between attempts
`timescale 1ns/1ns
`default_nettype none
module trr_partner_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // local page side
  input wire logic tx_valid,
  input wire logic [trr_pkg::SEED_W-1:0] tx_seed,
  // bench control
  input wire logic cfg_en,
  input wire logic cfg_force,
  input wire logic cfg_pref,
  input wire logic cfg_tie,
  input wire integer cfg_delay,
  // page toward the local port
  output logic rx_valid,
  output logic rx_force,
  output logic rx_pref,
  output logic [trr_pkg::SEED_W-1:0] rx_seed
);
  import trr_pkg::*;
  logic sent;
  logic tie_done;
  int cnt;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_valid <= 1'b0;
      rx_force <= 1'b0;
      rx_pref <= 1'b0;
      rx_seed <= 4'h0;
      sent <= 1'b0;
      tie_done <= 1'b0;
      cnt <= 0;
    end
    else
    begin
      rx_valid <= 1'b0;
      if (!cfg_tie)
      begin
        tie_done <= 1'b0;
      end
      // page lines no longer hold their value once valid has gone
      if (rx_valid)
      begin
        rx_force <= ~rx_force;
        rx_pref <= ~rx_pref;
        rx_seed <= ~rx_seed;
      end
      if (!tx_valid)
      begin
        sent <= 1'b0;
        cnt <= 0;
      end
      else if (cfg_en && !sent)
      begin
        if (cnt >= cfg_delay)
        begin
          // one equal seed on request, then the complement so ties end
          rx_valid <= 1'b1;
          rx_force <= cfg_force;
          rx_pref <= cfg_pref;
          rx_seed <= (cfg_tie && !tie_done) ? tx_seed : ~tx_seed;
          sent <= 1'b1;
          if (cfg_tie)
          begin
            tie_done <= 1'b1;
          end
        end
        else
          cnt <= cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/trr_role_resolution_tb_top.sv ***
// self-checking bench for the role resolution engine
// assumes one 100 MHz clock and the partner model on the page side
`timescale 1ns/1ns
`default_nettype none
module trr_role_resolution_tb_top;
  import trr_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic sw_reset = 1'b0;
  logic adv_high_wr_en = 1'b0;
  logic [ADV_W-1:0] adv_high_wdata = 16'h0000;
  logic adv_low_wr_en = 1'b0;
  logic [ADV_W-1:0] adv_low_wdata = 16'h0000;
  logic an_restart = 1'b0;
  logic link_quality_ok = 1'b1;
  logic p_en = 1'b1;
  logic p_force = 1'b0;
  logic p_pref = 1'b0;
  logic p_tie = 1'b0;
  int p_delay = 1;
  logic [ADV_W-1:0] adv_high;
  logic [ADV_W-1:0] adv_low;
  logic page_tx_valid;
  logic page_tx_force;
  logic page_tx_pref;
  logic [SEED_W-1:0] page_tx_seed;
  logic page_rx_valid;
  logic page_rx_force;
  logic page_rx_pref;
  logic [SEED_W-1:0] page_rx_seed;
  logic negotiation_complete;
  trr_role_t role_result;
  logic partner_role_force;
  logic partner_role_pref;
  logic link_status;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;

  trr_role_resolution #(.PORT_PREFERS_MASTER(1'b1)) uut (
    .sys_clk(sys_clk), .resetn(resetn), .sw_reset(sw_reset),
    .adv_high_wr_en(adv_high_wr_en), .adv_high_wdata(adv_high_wdata),
    .adv_low_wr_en(adv_low_wr_en), .adv_low_wdata(adv_low_wdata),
    .an_advert_ability_high(adv_high), .an_advert_ability_low(adv_low),
    .an_restart(an_restart), .page_tx_valid(page_tx_valid), .page_tx_force(page_tx_force),
    .page_tx_pref(page_tx_pref), .page_tx_seed(page_tx_seed), .page_rx_valid(page_rx_valid),
    .page_rx_force(page_rx_force), .page_rx_pref(page_rx_pref), .page_rx_seed(page_rx_seed),
    .link_quality_ok(link_quality_ok), .negotiation_complete(negotiation_complete),
    .role_result(role_result), .partner_role_force(partner_role_force),
    .partner_role_pref(partner_role_pref), .link_status(link_status));

  trr_partner_model partner (
    .sys_clk(sys_clk), .resetn(resetn), .tx_valid(page_tx_valid), .tx_seed(page_tx_seed),
    .cfg_en(p_en), .cfg_force(p_force), .cfg_pref(p_pref), .cfg_tie(p_tie),
    .cfg_delay(p_delay),
    .rx_valid(page_rx_valid), .rx_force(page_rx_force), .rx_pref(page_rx_pref),
    .rx_seed(page_rx_seed));

  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr_high(input logic [15:0] d);
    @(posedge sys_clk);
    adv_high_wr_en <= 1'b1;
    adv_high_wdata <= d;
    @(posedge sys_clk);
    adv_high_wr_en <= 1'b0;
  endtask

  task automatic wr_low(input logic [15:0] d);
    @(posedge sys_clk);
    adv_low_wr_en <= 1'b1;
    adv_low_wdata <= d;
    @(posedge sys_clk);
    adv_low_wr_en <= 1'b0;
  endtask

  task automatic restart();
    @(posedge sys_clk);
    an_restart <= 1'b1;
    @(posedge sys_clk);
    an_restart <= 1'b0;
  endtask

  // expected local role from both advertisements and both seeds
  function automatic trr_role_t exp_role(input logic lf, lp, pf, pp,
      input logic [3:0] ls, ps);
    if (lf && pf)
      return (lp == pp) ? ROLE_FAULT : (lp ? ROLE_MASTER : ROLE_SLAVE);
    if (lf || (lp != pp))
      return lp ? ROLE_MASTER : ROLE_SLAVE;
    if (pf)
      return pp ? ROLE_SLAVE : ROLE_MASTER;
    return (ls > ps) ? ROLE_MASTER : ROLE_SLAVE;
  endfunction

  task automatic test_reset();
    chk(adv_high, 16'h0010);
    chk(adv_low, 16'h0000);
    chk({role_result, negotiation_complete, link_status}, 16'h0000);
    $display("test reset done");
  endtask

  task automatic test_regs();
    wr_high(16'hA5C3);
    #1 chk(adv_high, 16'hA5C3);
    chk(page_tx_pref, 1'b0);
    wr_low(16'h0040);
    wr_high(16'h0010);
    #1 chk(adv_low, 16'h0040);
    chk({page_tx_force, page_tx_pref}, 2'h3);
    $display("test regs done");
  endtask

  // waits for the edge at which a page meets an open exchange window
  task automatic wait_page(output logic [3:0] ls);
    int n;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (!(page_tx_valid && page_rx_valid) && n < 200);
    ls = page_tx_seed;
    chk(n < 200, 1'b1);
  endtask

  task automatic attempt(input logic lf, lp, pf, pp, input int dly);
    logic [3:0] ls;
    trr_role_t e;
    wr_high(lp ? 16'h0010 : 16'h0000);
    wr_low(lf ? 16'h0040 : 16'h0000);
    p_force <= pf;
    p_pref <= pp;
    p_delay <= dly;
    restart();
    wait_page(ls);
    e = exp_role(lf, lp, pf, pp, ls, ~ls);
    repeat (2) @(posedge sys_clk);
    #1 chk({partner_role_force, partner_role_pref}, {pf, pp});
    chk(role_result, e);
    chk(negotiation_complete, e != ROLE_FAULT);
    chk(link_status, e != ROLE_FAULT);
    if (e == ROLE_FAULT)
    begin
      @(posedge sys_clk);
      #1 chk(page_tx_valid, 1'b1);
    end
    else
    begin
      chk(role_result == ROLE_MASTER, exp_role(pf, pp, lf, lp, ~ls, ls) == ROLE_SLAVE);
    end
  endtask

  task automatic test_table();
    for (int i = 0; i < 16; i++)
      attempt(i[3], i[2], i[1], i[0], (i % 3) * 15 + 1);
    $display("test table done");
  endtask

  task automatic test_tie();
    logic [3:0] ls;
    wr_high(16'h0000);
    wr_low(16'h0000);
    p_force <= 1'b0;
    p_pref <= 1'b0;
    p_delay <= 2;
    restart();
    p_tie <= 1'b1;
    wait_page(ls);
    repeat (2) @(posedge sys_clk);
    #1 chk({negotiation_complete, link_status, page_tx_valid}, 3'h1);
    wait_page(ls);
    repeat (2) @(posedge sys_clk);
    #1 chk(role_result, exp_role(1'b0, 1'b0, 1'b0, 1'b0, ls, ~ls));
    chk(negotiation_complete, 1'b1);
    p_tie <= 1'b0;
    $display("test tie done");
  endtask

  task automatic test_timeout();
    int n;
    p_en <= 1'b0;
    restart();
    @(posedge sys_clk);
    n = 0;
    while (!page_tx_valid && n < 10)
    begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    while (page_tx_valid && n < 1100)
    begin
      @(posedge sys_clk);
      n++;
    end
    #1 chk(16'(n), 16'(PAGE_TIMEOUT_CYC));
    chk(link_status, 1'b0);
    p_en <= 1'b1;
    $display("test timeout done");
  endtask

  task automatic test_quality();
    attempt(1'b0, 1'b1, 1'b0, 1'b0, 30);
    @(posedge sys_clk);
    link_quality_ok <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 chk({negotiation_complete, link_status}, 2'h0);
    chk(role_result, ROLE_MASTER);
    chk(page_tx_valid, 1'b1);
    @(posedge sys_clk);
    link_quality_ok <= 1'b1;
    $display("test quality done");
  endtask

  task automatic test_swreset();
    wr_high(16'h0000);
    wr_low(16'h0040);
    @(posedge sys_clk);
    sw_reset <= 1'b1;
    adv_low_wr_en <= 1'b1;
    adv_low_wdata <= 16'h0040;
    @(posedge sys_clk);
    sw_reset <= 1'b0;
    adv_low_wr_en <= 1'b0;
    #1 chk(adv_high, 16'h0010);
    chk(adv_low, 16'h0000);
    chk({negotiation_complete, link_status}, 2'h0);
    $display("test swreset done");
  endtask

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc >= 20000)
    begin
      fails++;
      end_sim();
    end
  end

  initial
  begin
    repeat (16) @(posedge sys_clk);
    test_reset();
    resetn <= 1'b1;
    test_regs();
    test_table();
    test_tie();
    test_timeout();
    test_quality();
    test_swreset();
    end_sim();
  end
endmodule
`default_nettype wire
